// ### core/deser_map.svh
`ifndef DESER_MAP_SVH
`define DESER_MAP_SVH

// Word framing: start bit, ten data bits, stop bit
`define DESER_WORD_BITS 12
`define DESER_DATA_BITS 10
`define DESER_POS_LAST 4'd11
`define DESER_POS_FIRST 4'd0
`define DESER_POS_WRAP 4'd12

// Recovered clock is high for the first half of the word
`define DESER_CLK_HIGH_BITS 4'd6

// Reference-loop settle count, in reference clock cycles
`define DESER_REF_LOCK_CYCLES 12'd2048

// Search give-up count, in reference clock cycles
`define DESER_SYNC_LOCK_CYCLES 6'd42

// Least number of recovered clock cycles the indicator stays high
`define DESER_LOCK_HOLD_CYCLES 2'd2

// Candidate mask with every bit position still possible
`define DESER_CAND_ALL 12'hfff

// Output staging buffer
`define DESER_FIFO_DEPTH 8

// Positions in the synchronised pin vector
`define DESER_PIN_COUNT 6
`define DESER_PIN_SER_POS 0
`define DESER_PIN_SER_NEG 1
`define DESER_PIN_LINK 2
`define DESER_PIN_REF 3
`define DESER_PIN_PWR 4
`define DESER_PIN_OE 5
`define DESER_PIN_SEL 6

`endif

// ### core/deser_pkg.sv
package deser_pkg;
`include "deser_map.svh"

   // Acquisition states
   typedef enum logic [2:0] {
      st_off,
      st_ref_lock,
      st_search,
      st_locked,
      st_hold
   } deser_state_e;

   typedef logic [`DESER_DATA_BITS-1:0] data_word_t;
   typedef logic [`DESER_WORD_BITS-1:0] frame_t;

   // Whole state of the control block
   typedef struct packed {
      deser_state_e st;
      logic [11:0] ref_cnt;
      logic [5:0] search_cnt;
      frame_t cand;
      logic seen;
      logic [3:0] pos;
      frame_t sh;
      logic link_q;
      logic ref_q;
      logic rclk;
      logic lock_n;
      logic strobe_seen;
      logic [1:0] hold_cnt;
      data_word_t dout;
      logic oe_data;
      logic oe_rclk;
      logic oe_lock;
   } deser_s;
endpackage

// ### core/deserializer_lock_output_ctrl.sv
// How it works
// - Strobe edge select picks rising or falling capture
// - Power-down stops loop, floats data, lock, clock
// - Output enable low floats data and clock
// - Lock indicator stays driven with outputs disabled
// - Lock low only after frame bits found
// - Data valid from second strobe edge after lock
// - Search restarts after 42 reference periods without lock
// - Locked recovered clock follows serializer word rate
// - Start high, ten data, stop low per word
// - Reference loop settles 2048 cycles, lock high
// - Missed edge raises lock two clocks minimum
`timescale 1ns/100ps
`include "deser_map.svh"
module deserializer_lock_output_ctrl (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Serial link pins
   input wire logic serial_in_pos_i,
   input wire logic serial_in_neg_i,
   input wire logic link_clock_i,
   // Control pins
   input wire logic reference_clock_in_i,
   input wire logic power_down_n_i,
   input wire logic output_enable_i,
   input wire logic strobe_edge_select_i,
   // Parallel data pins
   output deser_pkg::data_word_t parallel_data_bits_o,
   output logic parallel_data_oe_o,
   // Recovered clock pin
   output logic recovered_clock_o,
   output logic recovered_clock_oe_o,
   // Lock indicator pin, active low
   output logic lock_n_o,
   output logic lock_oe_o
);
   import deser_pkg::*;

   deser_s r;
   deser_s next_r;
   logic [`DESER_PIN_COUNT:0] pins;
   logic [`DESER_PIN_COUNT:0] lvl;
   logic ser_bit;
   logic link_rise;
   logic ref_rise;
   logic pwr_on;
   logic rising;
   frame_t cand_w;
   logic [3:0] cand_idx;
   logic cand_one;
   logic next_rclk;
   logic rclk_rise;
   logic rclk_fall;
   logic strobe;
   logic launch;
   logic lost;
   logic push;
   data_word_t push_data;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   data_word_t fifo_out_data;
   logic pop;

   // Every pin from outside passes the three-stage filter
   assign pins = {strobe_edge_select_i, output_enable_i, power_down_n_i,
                  reference_clock_in_i, link_clock_i, serial_in_neg_i,
                  serial_in_pos_i};

   pin_sync #(
      .WIDTH(`DESER_PIN_COUNT + 1)
   ) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pin_i(pins),
      .level_o(lvl)
   );

   // Differential pair read as one bit; equal legs read as low
   assign ser_bit = lvl[`DESER_PIN_SER_POS] & ~lvl[`DESER_PIN_SER_NEG];
   assign pwr_on = lvl[`DESER_PIN_PWR];
   assign link_rise = lvl[`DESER_PIN_LINK] & ~r.link_q;
   assign ref_rise = lvl[`DESER_PIN_REF] & ~r.ref_q;

   // Embedded edge test: stop bit low, then start bit high
   assign rising = ~r.sh[0] & ser_bit;

   // Drop positions that showed no rising edge this bit
   always_comb begin
      cand_w = r.cand;
      if (!rising) begin
         cand_w[r.pos] = 1'b0;
      end
   end

   // Single surviving candidate and its position
   assign cand_one = (cand_w != '0) &&
                     ((cand_w & (cand_w - frame_t'(1))) == '0);

   always_comb begin
      cand_idx = '0;
      for (int i = 0; i < `DESER_WORD_BITS; i++) begin
         if (cand_w[i]) begin
            cand_idx = 4'(i);
         end
      end
   end

   // Data bit 0 is the first received after the start bit
   always_comb begin
      push_data = '0;
      for (int i = 0; i < `DESER_DATA_BITS; i++) begin
         push_data[i] = r.sh[`DESER_DATA_BITS-1-i];
      end
   end

   // Recovered clock source and its edges
   always_comb begin
      if (r.lock_n) begin
         next_rclk = lvl[`DESER_PIN_REF];
      end else begin
         next_rclk = (r.pos < `DESER_CLK_HIGH_BITS);
      end
   end

   assign rclk_rise = next_rclk & ~r.rclk;
   assign rclk_fall = ~next_rclk & r.rclk;
   // Launch on the opposite edge so data is stable at the strobe
   assign strobe = lvl[`DESER_PIN_SEL] ? rclk_rise : rclk_fall;
   assign launch = lvl[`DESER_PIN_SEL] ? rclk_fall : rclk_rise;

   // Words leave the buffer one per launch edge once valid
   assign pop = launch & ~r.lock_n & r.strobe_seen & fifo_out_valid;
   // Flushed outside lock; kept while the indicator waits for a word
   assign fifo_out_ready = (r.st != st_locked) | pop;

   // Word pushed at the stop bit of each locked frame
   assign push = (r.st == st_locked) && link_rise &&
                 (r.pos == `DESER_POS_LAST);

   // Missing embedded edge or a full buffer both drop lock
   assign lost = (r.st == st_locked) && link_rise &&
                 (((r.pos == `DESER_POS_FIRST) && !rising) ||
                  (push && !fifo_in_ready));

   word_fifo #(
      .WIDTH(`DESER_DATA_BITS),
      .DEPTH(`DESER_FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(push_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // Acquisition, lock and output control
   always_comb begin
      next_r = r;
      next_r.link_q = lvl[`DESER_PIN_LINK];
      next_r.ref_q = lvl[`DESER_PIN_REF];
      next_r.rclk = next_rclk;

      // Shift in one bit per rising link clock edge
      if (link_rise) begin
         next_r.sh = {r.sh[`DESER_WORD_BITS-2:0], ser_bit};
         if (r.pos == `DESER_POS_LAST) begin
            next_r.pos = `DESER_POS_FIRST;
         end else begin
            next_r.pos = r.pos + 4'd1;
         end
      end

      unique case (r.st)
         st_off: begin
            next_r.st = st_ref_lock;
            next_r.ref_cnt = '0;
         end
         st_ref_lock: begin
            // Loop settles on the reference first, indicator high
            if (ref_rise) begin
               if (r.ref_cnt == `DESER_REF_LOCK_CYCLES - 12'd1) begin
                  next_r.st = st_search;
                  next_r.cand = `DESER_CAND_ALL;
                  next_r.seen = 1'b0;
                  next_r.search_cnt = '0;
               end else begin
                  next_r.ref_cnt = r.ref_cnt + 12'd1;
               end
            end
         end
         st_search: begin
            if (ref_rise) begin
               next_r.search_cnt = r.search_cnt + 6'd1;
            end
            if (link_rise) begin
               next_r.cand = cand_w;
               if (r.pos == `DESER_POS_LAST) begin
                  if (cand_one && r.seen) begin
                     // Same edge seen two words in a row
                     next_r.st = st_locked;
                     if (cand_idx == `DESER_POS_FIRST) begin
                        next_r.pos = `DESER_POS_FIRST;
                     end else begin
                        next_r.pos = `DESER_POS_WRAP - cand_idx;
                     end
                  end else if (cand_one) begin
                     next_r.seen = 1'b1;
                  end else if (cand_w == '0) begin
                     // Every position ruled out: start over
                     next_r.cand = `DESER_CAND_ALL;
                     next_r.seen = 1'b0;
                  end else begin
                     next_r.seen = 1'b0;
                  end
               end
            end
            // Give up on a stuck search and begin afresh
            if (r.search_cnt == `DESER_SYNC_LOCK_CYCLES) begin
               next_r.cand = `DESER_CAND_ALL;
               next_r.seen = 1'b0;
               next_r.search_cnt = '0;
            end
         end
         st_locked: begin
            if (lost) begin
               next_r.st = st_hold;
               next_r.hold_cnt = '0;
            end
         end
         st_hold: begin
            // Count recovered clocks only once the indicator is high
            if (r.lock_n && rclk_rise) begin
               if (r.hold_cnt == `DESER_LOCK_HOLD_CYCLES - 2'd1) begin
                  next_r.st = st_search;
                  next_r.cand = `DESER_CAND_ALL;
                  next_r.seen = 1'b0;
                  next_r.search_cnt = '0;
               end else begin
                  next_r.hold_cnt = r.hold_cnt + 2'd1;
               end
            end
         end
         default: begin
            next_r.st = st_off;
         end
      endcase

      // Indicator and data move together on launch edges
      // Falls only with a word buffered, so the second strobe is valid
      if (launch) begin
         next_r.lock_n = (r.st != st_locked) ||
                         (r.lock_n && !fifo_out_valid);
         if (r.st != st_locked) begin
            next_r.strobe_seen = 1'b0;
         end
      end
      if (strobe && !r.lock_n) begin
         next_r.strobe_seen = 1'b1;
      end
      if (pop) begin
         next_r.dout = fifo_out_data;
      end

      // Output drivers; indicator ignores output enable
      next_r.oe_lock = pwr_on;
      next_r.oe_rclk = pwr_on && lvl[`DESER_PIN_OE] &&
                       (r.st != st_off) && (r.st != st_ref_lock);
      next_r.oe_data = next_r.oe_rclk;

      // Power-down halts everything; its release restarts init
      if (!pwr_on) begin
         next_r.st = st_off;
         next_r.lock_n = 1'b1;
         next_r.strobe_seen = 1'b0;
         next_r.rclk = 1'b0;
         next_r.pos = `DESER_POS_FIRST;
      end
   end

   // Single state register
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{st: st_off, lock_n: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // All pin values straight from flip-flops
   assign parallel_data_bits_o = r.dout;
   assign parallel_data_oe_o = r.oe_data;
   assign recovered_clock_o = r.rclk;
   assign recovered_clock_oe_o = r.oe_rclk;
   assign lock_n_o = r.lock_n;
   assign lock_oe_o = r.oe_lock;
endmodule

// ### core/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Raw pins and filtered levels
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sync_s;

   sync_s r;
   sync_s next_r;

   // Level moves only when the two later stages agree
   always_comb begin
      next_r = r;
      next_r.s1 = pin_i;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.lvl[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign level_o = r.lvl;
endmodule

// ### core/word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_s;

   fifo_s r;
   fifo_s next_r;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign empty = (r.wr == r.rd);
   assign full = (r.wr[AW] != r.rd[AW]) && (r.wr[AW-1:0] == r.rd[AW-1:0]);
   assign in_ready_o = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o = r.mem[r.rd[AW-1:0]];

   always_comb begin
      next_r = r;
      if (in_valid_i && !full) begin
         next_r.mem[r.wr[AW-1:0]] = in_data_i;
         next_r.wr = r.wr + {{AW{1'b0}}, 1'b1};
      end
      if (out_ready_i && !empty) begin
         next_r.rd = r.rd + {{AW{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

// ### tb/lock_properties.sv
`timescale 1ns/100ps
module lock_props (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Control pins
   input wire logic reference_clock_in_i,
   input wire logic power_down_n_i,
   input wire logic output_enable_i,
   input wire logic strobe_edge_select_i,
   // Outputs watched
   input wire deser_pkg::data_word_t parallel_data_bits_o,
   input wire logic parallel_data_oe_o,
   input wire logic recovered_clock_o,
   input wire logic recovered_clock_oe_o,
   input wire logic lock_n_o,
   input wire logic lock_oe_o
);
   import deser_pkg::*;
   logic [11:0] ref_cnt;
   logic [1:0] hold_cnt;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // Raw pin counts run ahead of the synced ones, so bounds stay safe
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cnt <= '0;
         hold_cnt <= '0;
      end else begin
         if (!power_down_n_i) begin
            ref_cnt <= '0;
         end else if ($rose(reference_clock_in_i) && ref_cnt != 12'hfff) begin
            ref_cnt <= ref_cnt + 12'h1;
         end
         if (!lock_n_o) begin
            hold_cnt <= '0;
         end else if ($rose(recovered_clock_o) && hold_cnt != 2'h3) begin
            hold_cnt <= hold_cnt + 2'h1;
         end
      end
   end
   pdn_float_a:
      assert property (!power_down_n_i [*8] |-> !lock_oe_o &&
         !parallel_data_oe_o && !recovered_clock_oe_o)
      else $error("outputs driven in power-down");
   oe_float_a:
      assert property (!output_enable_i [*8] |-> !parallel_data_oe_o &&
         !recovered_clock_oe_o)
      else $error("data or clock driven while disabled");
   lock_drive_a:
      assert property (power_down_n_i [*8] |-> lock_oe_o)
      else $error("lock indicator not driven");
   rise_strobe_a:
      assert property ((strobe_edge_select_i && power_down_n_i) [*8] ##0
         $rose(recovered_clock_o) |-> $stable(parallel_data_bits_o))
      else $error("data moved on rising strobe");
   fall_strobe_a:
      assert property ((!strobe_edge_select_i && power_down_n_i) [*8] ##0
         $fell(recovered_clock_o) |-> $stable(parallel_data_bits_o))
      else $error("data moved on falling strobe");
   hold_two_a:
      assert property ($fell(lock_n_o) && lock_oe_o |-> hold_cnt >= 2'h2)
      else $error("lock regained too soon");
   ref_follow_a:
      assert property ((lock_n_o && recovered_clock_oe_o) [*8] ##0
         $rose(reference_clock_in_i) |->
         ##[1:8] ($rose(recovered_clock_o) || !lock_n_o))
      else $error("clock not following reference");
   ref_settle_a:
      assert property (power_down_n_i [*8] ##0
         (!lock_n_o || parallel_data_oe_o) |-> ref_cnt >= 12'h800)
      else $error("active before reference settled");
   cover property ($fell(lock_n_o));
   cover property (!output_enable_i && !lock_n_o);
   cover property ($rose(lock_n_o) && lock_oe_o);
endmodule

bind deserializer_lock_output_ctrl lock_props u_props (.*);

// ### tb/ser_model.sv
`timescale 1ns/100ps
module ser_model (
   // Controls from the bench
   input wire logic run_i,
   input wire logic sync_i,
   input wire logic miss_i,
   input wire logic [9:0] word_i,
   // Link pins and frame marker
   output logic link_clock_o,
   output logic ser_pos_o,
   output logic ser_neg_o,
   output logic frame_o
);
   logic [11:0] fr;
   // Word period equals the bench reference period, well inside 400ppm
   initial begin
      link_clock_o = 1'b0;
      ser_pos_o = 1'b0;
      ser_neg_o = 1'b1;
      frame_o = 1'b0;
      #3;
      forever begin
         wait (run_i);
         // Start high, data first bit first, stop low; miss drops start
         fr = sync_i ? 12'h03f : {1'b0, word_i, 1'b1};
         fr[0] = !miss_i;
         frame_o = !frame_o;
         for (int i = 0; i < 12; i++) begin
            ser_pos_o = fr[i];
            ser_neg_o = !fr[i];
            #80 link_clock_o = 1'b1;
            #80 link_clock_o = 1'b0;
         end
         // Released lines show the inverse of the last bit
         if (!run_i) begin
            ser_pos_o = !ser_pos_o;
            ser_neg_o = !ser_neg_o;
         end
      end
   end
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
   import deser_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic ref_clk = 1'b0;
   logic pwr_n = 1'b1;
   logic oe = 1'b1;
   logic sel = 1'b1;
   logic run = 1'b0;
   logic sync = 1'b1;
   logic miss = 1'b0;
   data_word_t word = 10'h000;
   data_word_t dout;
   logic lclk, spos, sneg, frame, dout_oe, rclk, rclk_oe, lock_n, lock_oe;
   int ref_half = 24;
   int err_count = 0;
   int check_count = 0;
   // Clocks; reference edges land on falling system edges
   always #4 clock_i = ~clock_i;
   always #(ref_half) ref_clk = ~ref_clk;
   ser_model u_ser (.run_i(run), .sync_i(sync), .miss_i(miss),
      .word_i(word), .link_clock_o(lclk), .ser_pos_o(spos),
      .ser_neg_o(sneg), .frame_o(frame));
   deserializer_lock_output_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i),
      .serial_in_pos_i(spos), .serial_in_neg_i(sneg), .link_clock_i(lclk),
      .reference_clock_in_i(ref_clk), .power_down_n_i(pwr_n),
      .output_enable_i(oe), .strobe_edge_select_i(sel),
      .parallel_data_bits_o(dout), .parallel_data_oe_o(dout_oe),
      .recovered_clock_o(rclk), .recovered_clock_oe_o(rclk_oe),
      .lock_n_o(lock_n), .lock_oe_o(lock_oe));
   task automatic tick(int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Next selected strobe edge, seen half a cycle after it lands
   task automatic strobe;
      logic prev;
      prev = rclk;
      for (int i = 0; i < 2000; i++) begin
         @(negedge clock_i);
         if (rclk !== prev && rclk === sel) break;
         prev = rclk;
      end
   endtask
   // Bound is 42 word-rate reference periods
   task automatic wait_lock(logic lvl, output int n);
      n = 0;
      while (lock_n !== lvl && n < 10080) begin
         @(negedge clock_i);
         n++;
      end
   endtask
   task automatic t_ref_lock;
      tick(12000);
      check("early data oe", dout_oe, 1'b0);
      tick(600);
      check("data oe", dout_oe, 1'b1);
      // Slow reference to the word rate once settled
      ref_half = 960;
      @(posedge ref_clk);
      tick(8);
      check("clock copies reference", rclk, ref_clk);
      check("lock idle", lock_n, 1'b1);
   endtask
   task automatic t_sync_lock;
      int n;
      run = 1'b1;
      wait_lock(1'b0, n);
      check("lock in time", lock_n, 1'b0);
      check("lock not early", n >= 200, 1'b1);
      strobe;
      strobe;
      check("first valid word", dout, 10'h01f);
   endtask
   task automatic t_data(logic s, data_word_t w);
      time t0;
      sel = s;
      sync = 1'b0;
      word = w;
      tick(960);
      strobe;
      check("word at strobe", dout, w);
      // Model word period, 12 bits of 160 ns, in system clocks
      t0 = $time;
      strobe;
      check("strobe period", 10'(($time - t0) / 8), 10'd240);
   endtask
   task automatic t_oe;
      oe = 1'b0;
      tick(10);
      check("data oe off", dout_oe, 1'b0);
      check("clock oe off", rclk_oe, 1'b0);
      check("lock oe kept", lock_oe, 1'b1);
      check("lock kept", lock_n, 1'b0);
      oe = 1'b1;
      tick(10);
      check("data oe back", dout_oe, 1'b1);
   endtask
   task automatic t_miss;
      int n;
      int rises;
      logic prev;
      sync = 1'b1;
      @(frame);
      miss = 1'b1;
      @(frame);
      miss = 1'b0;
      wait_lock(1'b1, n);
      check("lock lost", lock_n, 1'b1);
      rises = 0;
      n = 0;
      prev = rclk;
      while (lock_n === 1'b1 && n < 10080) begin
         @(negedge clock_i);
         if (rclk === 1'b1 && prev === 1'b0) rises++;
         prev = rclk;
         n++;
      end
      check("relocked", lock_n, 1'b0);
      check("held two clocks", rises >= 2, 1'b1);
   endtask
   task automatic t_pdn;
      pwr_n = 1'b0;
      tick(10);
      check("lock oe off", lock_oe, 1'b0);
      check("data oe off", dout_oe, 1'b0);
      check("clock oe off", rclk_oe, 1'b0);
      ref_half = 24;
      pwr_n = 1'b1;
      tick(1000);
      check("restart data oe", dout_oe, 1'b0);
      check("restart lock", lock_n, 1'b1);
   endtask
   // Main sequence
   initial begin
      tick(6);
      rst_i = 1'b0;
      t_ref_lock;
      t_sync_lock;
      t_data(1'b1, 10'h2b5);
      t_data(1'b0, 10'h14a);
      t_oe;
      t_miss;
      t_pdn;
      end_of_test;
   end
   // Watchdog, about twice the expected run
   initial begin
      repeat (40000) @(posedge clock_i);
      err_count++;
      end_of_test;
   end
endmodule
